/* rtl/nfc_fifo.sv */
// Purpose: write data buffer between user and flash bus sequencer
// Assumes: single clock, depth a power of two
// Notes:   full and empty come from an occupancy count
`timescale 1ns/1ns
module nfc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt;
    logic [AW-1:0]    rd_ptr_r, rd_ptr_nxt;
    logic [AW:0]      count_r,  count_nxt;
    logic             push, pop;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
        count_nxt  = count_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end
endmodule // nfc_fifo

/* rtl/nfc_host.sv */
// Purpose: host side sequencer driving an asynchronous nand flash bus
// Assumes: 20 MHz clk; pins pass two flops before use; external pull-up on ready_busy_n
// Notes:   one request moves one command, one five-cycle address, or one data word
// What the document says of device and host
// RULE_01 - device latches the command byte on write strobe rise with command latch high.
// RULE_02 - device latches an address byte on write strobe rise with address latch high.
// RULE_03 - device latches data words on the rising write strobe.
// RULE_04 - chip enable high deselects the device and floats its bus.
// RULE_05 - chip enable low selects the device for bus cycles.
// RULE_06 - each read strobe fall outputs the next word, column advancing.
// RULE_07 - device refuses program and erase while write protect is low.
// RULE_08 - device holds ready_busy_n low during array operations.
// RULE_09 - ready_busy_n is open drain; host supplies the pull-up.
// RULE_10 - one shared bus; host turns it around, device drives only reads.
// RULE_11 - 4096 blocks of 64 pages, 2112 bytes or 1056 words each.
// RULE_12 - page has 2048 main plus 64 spare bytes, or 1024 plus 32 words.
// RULE_13 - byte mode column: bits 7..0, then bits 11..8 with upper bits low.
// RULE_14 - byte mode row: 19..12, 27..20, then 29..28 with upper bits low.
// RULE_15 - device uses address bit 18 as plane select in byte mode.
// RULE_16 - word mode column: bits 7..0, then 10..8, all other lines low.
// RULE_17 - word mode row: 18..11, 26..19, then 28..27, other lines low.
// RULE_18 - every unused bus line is low during each address cycle.
// RULE_19 - device ignores surplus address cycles.
// RULE_20 - after power-up the device already holds the page read opener.
// RULE_21 - host never sends a command outside the defined set.
// RULE_22 - host waits for ready before strobing data out after array read.
`timescale 1ns/1ns
module nfc_host #(
    parameter bit WIDE = 1'b0,
    parameter int IO_W = WIDE ? 16 : 8
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire nfc_pkg::nfc_req_s  req,
    input  wire logic               wr_valid,
    output logic                    wr_ready,
    input  wire logic [IO_W-1:0]    wr_data,
    output logic                    rd_valid,
    output logic      [IO_W-1:0]    rd_data,
    output logic                    cmd_err,
    input  wire logic               write_protect,
    output nfc_pkg::nfc_ctl_s       ctl,
    output logic      [IO_W-1:0]    io_out,
    output logic                    io_oe,
    input  wire logic [IO_W-1:0]    io_in,
    input  wire logic               ready_busy_n
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10,
        ST_WAIT = 2'b11
    } nfc_state_e;

    localparam logic [nfc_pkg::COL_W-1:0] COL_LAST = WIDE ?
        nfc_pkg::COL_W'(nfc_pkg::PAGE_WORDS - 1) : nfc_pkg::COL_W'(nfc_pkg::PAGE_BYTES - 1);

    function automatic logic cmd_legal(input logic [7:0] c);
        cmd_legal = 1'b0;
        for (int i = 0; i < nfc_pkg::N_LEGAL; i++) begin
            if (nfc_pkg::LEGAL_CMDS[i] == c) cmd_legal = 1'b1;
        end
    endfunction

    function automatic logic cmd_busy(input logic [7:0] c);
        cmd_busy = 1'b0;
        for (int i = 0; i < nfc_pkg::N_BUSY; i++) begin
            if (nfc_pkg::BUSY_CMDS[i] == c) cmd_busy = 1'b1;
        end
    endfunction

    // one address cycle; unused lines forced low
    function automatic logic [IO_W-1:0] addr_word(input logic [2:0] i,
                                                  input logic [nfc_pkg::COL_W-1:0] c,
                                                  input logic [nfc_pkg::ROW_W-1:0] r);
        logic [7:0] b;
        b = 8'h00;
        unique case (i)
            3'h0: b = c[7:0];                                            // RULE_13
            3'h1: b = WIDE ? {5'h00, c[10:8]} : {4'h0, c[11:8]};         // RULE_16
            3'h2: b = r[7:0];                                            // RULE_14
            3'h3: b = r[15:8];                                           // RULE_17
            default: b = {6'h00, r[17:16]};                              // RULE_14
        endcase
        addr_word = IO_W'(b);                                            // RULE_18
    endfunction

    nfc_state_e                  state_r, state_nxt;
    logic [nfc_pkg::CNT_W-1:0]   cnt_r, cnt_nxt;
    logic [2:0]                  idx_r, idx_nxt;
    nfc_pkg::nfc_op_e            op_r, op_nxt;
    logic [nfc_pkg::COL_W-1:0]   col_r, col_nxt;
    logic [nfc_pkg::ROW_W-1:0]   row_r, row_nxt;
    nfc_pkg::nfc_ctl_s           ctl_r, ctl_nxt;
    logic [IO_W-1:0]             io_out_r, io_out_nxt;
    logic                        io_oe_r, io_oe_nxt;
    logic [IO_W-1:0]             rd_data_r, rd_data_nxt;
    logic                        rd_valid_r, rd_valid_nxt;
    logic                        cmd_err_r, cmd_err_nxt;
    logic                        pend_r, pend_nxt;
    logic                        rb_s1, rb_s2;
    logic [IO_W-1:0]             io_s1, io_s2;
    logic                        fifo_valid, fifo_pop;
    logic [IO_W-1:0]             fifo_data;
    logic                        accept;

    nfc_fifo #(.WIDTH(IO_W), .DEPTH(nfc_pkg::FIFO_DEPTH)) u_nfc_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // reads are held back while an array operation may still be busy
    assign req_ready = (state_r == ST_IDLE)
                     && !(req.op == nfc_pkg::OP_WRITE && !fifo_valid)
                     && !(req.op == nfc_pkg::OP_READ && pend_r);                 // RULE_22
    assign accept    = req_valid && req_ready;
    assign fifo_pop  = accept && (req.op == nfc_pkg::OP_WRITE);

    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        idx_nxt      = idx_r;
        op_nxt       = op_r;
        col_nxt      = col_r;
        row_nxt      = row_r;
        ctl_nxt      = ctl_r;
        io_out_nxt   = io_out_r;
        io_oe_nxt    = io_oe_r;
        rd_data_nxt  = rd_data_r;
        rd_valid_nxt = 1'b0;
        cmd_err_nxt  = 1'b0;
        pend_nxt     = pend_r;
        ctl_nxt.wp_n = ~write_protect;                                            // RULE_07
        unique case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    op_nxt  = req.op;
                    col_nxt = req.col;
                    row_nxt = req.row;
                    idx_nxt = 3'h0;
                    cnt_nxt = nfc_pkg::CNT_W'(nfc_pkg::WE_LOW_CYC - 1);
                    unique case (req.op)
                        nfc_pkg::OP_CMD: begin
                            if (!cmd_legal(req.cmd)) begin
                                cmd_err_nxt = 1'b1;                               // RULE_21
                            end else begin
                                ctl_nxt.cle  = 1'b1;
                                ctl_nxt.we_n = 1'b0;
                                io_out_nxt   = IO_W'(req.cmd);
                                io_oe_nxt    = 1'b1;                              // RULE_10
                                state_nxt    = ST_LOW;
                                if (cmd_busy(req.cmd)) pend_nxt = 1'b1;
                            end
                        end
                        nfc_pkg::OP_ADDR: begin
                            if (req.col > COL_LAST) begin
                                cmd_err_nxt = 1'b1;                               // RULE_11 RULE_12
                            end else begin
                                ctl_nxt.ale  = 1'b1;
                                ctl_nxt.we_n = 1'b0;
                                io_out_nxt   = addr_word(3'h0, req.col, req.row);
                                io_oe_nxt    = 1'b1;
                                state_nxt    = ST_LOW;
                            end
                        end
                        nfc_pkg::OP_WRITE: begin
                            ctl_nxt.we_n = 1'b0;
                            io_out_nxt   = fifo_data;
                            io_oe_nxt    = 1'b1;
                            state_nxt    = ST_LOW;
                        end
                        nfc_pkg::OP_READ: begin
                            ctl_nxt.re_n = 1'b0;
                            io_oe_nxt    = 1'b0;                                  // RULE_10
                            cnt_nxt      = nfc_pkg::CNT_W'(nfc_pkg::RE_LOW_CYC - 1);
                            state_nxt    = ST_LOW;
                        end
                        nfc_pkg::OP_WAIT: begin
                            cnt_nxt   = nfc_pkg::CNT_W'(nfc_pkg::BUSY_SETTLE_CYC - 1);
                            state_nxt = ST_WAIT;
                        end
                        default: cmd_err_nxt = 1'b1;
                    endcase
                end else if (req_valid && req.op == nfc_pkg::OP_READ && pend_r) begin
                    cnt_nxt   = nfc_pkg::CNT_W'(nfc_pkg::BUSY_SETTLE_CYC - 1);
                    state_nxt = ST_WAIT;                                          // RULE_22
                end
            end
            ST_LOW: begin
                if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - 1'b1;
                end else begin
                    if (op_r == nfc_pkg::OP_READ) begin
                        ctl_nxt.re_n = 1'b1;
                        rd_data_nxt  = io_s2;
                        rd_valid_nxt = 1'b1;
                    end else begin
                        ctl_nxt.we_n = 1'b1;
                    end
                    cnt_nxt   = nfc_pkg::CNT_W'(nfc_pkg::WE_HIGH_CYC - 1);
                    state_nxt = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - 1'b1;
                end else if (op_r == nfc_pkg::OP_ADDR
                             && idx_r != 3'(nfc_pkg::ADDR_CYCLES - 1)) begin
                    idx_nxt      = idx_r + 1'b1;
                    io_out_nxt   = addr_word(idx_r + 1'b1, col_r, row_r);
                    ctl_nxt.we_n = 1'b0;
                    cnt_nxt      = nfc_pkg::CNT_W'(nfc_pkg::WE_LOW_CYC - 1);
                    state_nxt    = ST_LOW;
                end else begin
                    ctl_nxt.cle = 1'b0;
                    ctl_nxt.ale = 1'b0;
                    io_oe_nxt   = 1'b0;                                           // RULE_10
                    state_nxt   = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - 1'b1;
                end else if (rb_s2) begin
                    pend_nxt  = 1'b0;                                             // RULE_09
                    state_nxt = ST_IDLE;
                end
            end
        endcase
        // released only when idle and no array operation outstanding
        ctl_nxt.ce_n = (state_nxt == ST_IDLE) && !pend_nxt;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= ST_IDLE;
            cnt_r      <= '0;
            idx_r      <= 3'h0;
            op_r       <= nfc_pkg::OP_CMD;
            col_r      <= '0;
            row_r      <= '0;
            ctl_r      <= nfc_pkg::CTL_RESET;
            io_out_r   <= '0;
            io_oe_r    <= 1'b0;
            rd_data_r  <= '0;
            rd_valid_r <= 1'b0;
            cmd_err_r  <= 1'b0;
            pend_r     <= 1'b0;
            rb_s1      <= 1'b1;
            rb_s2      <= 1'b1;
            io_s1      <= '0;
            io_s2      <= '0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            idx_r      <= idx_nxt;
            op_r       <= op_nxt;
            col_r      <= col_nxt;
            row_r      <= row_nxt;
            ctl_r      <= ctl_nxt;
            io_out_r   <= io_out_nxt;
            io_oe_r    <= io_oe_nxt;
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            cmd_err_r  <= cmd_err_nxt;
            pend_r     <= pend_nxt;
            rb_s1      <= ready_busy_n;
            rb_s2      <= rb_s1;
            io_s1      <= io_in;
            io_s2      <= io_s1;
        end
    end

    assign ctl      = ctl_r;
    assign io_out   = io_out_r;
    assign io_oe    = io_oe_r;
    assign rd_data  = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign cmd_err  = cmd_err_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_oe_read_excl: assert property (io_oe |-> ctl.re_n) // RULE_10
        else $error("bus driven while read strobe low");
    a_rd_sample: assert property ($rose(ctl.re_n) |-> rd_valid && !$past(ctl.re_n, 3)) // RULE_10
        else $error("read word not delivered at strobe rise");
    a_read_ready: assert property ($fell(ctl.re_n) |-> !pend_r && !$past(pend_r)) // RULE_22
        else $error("read strobe while array busy outstanding");
    a_bad_cmd: assert property (accept && req.op == nfc_pkg::OP_CMD && !cmd_legal(req.cmd)
                                |=> cmd_err && !ctl.cle && ctl.we_n) // RULE_21
        else $error("undefined command reached the bus");
    a_col_upper: assert property (ctl.ale && !ctl.we_n && idx_r == 3'h1
                                  |-> (io_out >> (WIDE ? 3 : 4)) == '0) // RULE_13
        else $error("column high cycle carries stray bits");
    a_row_last: assert property (ctl.ale && !ctl.we_n && idx_r == 3'h4
                                 |-> (io_out >> 2) == '0) // RULE_17
        else $error("last row cycle carries stray bits");
    a_addr_hold: assert property (ctl.ale && $fell(ctl.we_n)
                                  |=> $stable(io_out) && io_oe) // RULE_18
        else $error("address byte changed around strobe rise");
    a_page_col: assert property (accept && req.op == nfc_pkg::OP_ADDR && req.col > COL_LAST
                                 |=> cmd_err && !ctl.ale) // RULE_12
        else $error("column beyond page accepted");
    a_wait_ready: assert property ($fell(pend_r) |-> // RULE_09
                                   $past(rb_s2) && $past(state_r) == ST_WAIT)
        else $error("busy cleared without ready level");

    c_cmd: cover property ($rose(ctl.cle));
    c_addr5: cover property (ctl.ale && idx_r == 3'h4 && $rose(ctl.we_n));
    c_write: cover property (fifo_pop ##[1:20] !wr_ready);
    c_read: cover property ($fell(pend_r) ##[1:20] rd_valid);
endmodule // nfc_host

/* shared/nfc_pkg.sv */
// Purpose: constants, types and pin bundles for the nand flash bus controller
// Assumes: 20 MHz clk, asynchronous nand flash on the far side of the pins
// Notes:   times are in ns and turned into whole clock cycles here
package nfc_pkg;
    localparam int CLK_NS                  = 50;
    // strobe and turnaround times, least times round up
    localparam int WE_LOW_NS               = 50;
    localparam int WE_HIGH_NS              = 50;
    localparam int OUTPUT_ACCESS_DELAY_NS  = 25;
    localparam int BUSY_SETTLE_NS          = 100;
    localparam int SYNC_STAGES             = 2;
    localparam int WE_LOW_CYC  = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int OUTPUT_ACCESS_DELAY_CYC = (OUTPUT_ACCESS_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int RE_LOW_CYC  = OUTPUT_ACCESS_DELAY_CYC + SYNC_STAGES;
    localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W       = 4;

    // array geometry
    localparam int BLOCKS          = 4096;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int MAIN_BYTES      = 2048;
    localparam int SPARE_BYTES     = 64;
    localparam int PAGE_BYTES      = 2112;
    localparam int MAIN_WORDS      = 1024;
    localparam int SPARE_WORDS     = 32;
    localparam int PAGE_WORDS      = 1056;
    localparam int COL_W           = 12;
    localparam int ROW_W           = 18;
    localparam int ADDR_CYCLES     = 5;
    localparam int FIFO_DEPTH      = 8;

    // defined command set
    localparam int N_LEGAL = 22;
    localparam logic [7:0] LEGAL_CMDS [N_LEGAL] = '{
        8'h00, 8'h30, 8'h35, 8'h90, 8'h70, 8'hFF, 8'h80, 8'h85, 8'h10, 8'h60, 8'hD0,
        8'h05, 8'hE0, 8'hEC, 8'hED, 8'hEE, 8'hEF, 8'h78, 8'h06, 8'h11, 8'h81, 8'hD1};
    // commands after which the device goes busy
    localparam int N_BUSY = 9;
    localparam logic [7:0] BUSY_CMDS [N_BUSY] = '{
        8'h30, 8'h35, 8'h10, 8'hD0, 8'hFF, 8'h11, 8'hD1, 8'hEC, 8'hED};

    typedef enum logic [2:0] {
        OP_CMD   = 3'b000,
        OP_ADDR  = 3'b001,
        OP_WRITE = 3'b010,
        OP_READ  = 3'b011,
        OP_WAIT  = 3'b100
    } nfc_op_e;

    typedef struct packed {
        nfc_op_e            op;
        logic [7:0]         cmd;
        logic [COL_W-1:0]   col;
        logic [ROW_W-1:0]   row;
    } nfc_req_s;

    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic wp_n;
    } nfc_ctl_s;

    localparam nfc_ctl_s CTL_RESET = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0,
                                       we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
endpackage

/* verification/nfc_flash_model.sv */
// Purpose: behavioural flash device on the far side of the host pins
// Assumes: byte bus; times in ns; page data is col xor A5
// Notes:   a released bus shows the inverse of its last value
`timescale 1ns/1ns
module nfc_flash_model #(
    parameter int IO_W    = 8,
    parameter int BUSY_NS = 2000,
    parameter int OUT_NS  = 25
) (
    input  wire nfc_pkg::nfc_ctl_s ctl,
    input  wire logic [IO_W-1:0]   io,
    output logic      [IO_W-1:0]   dev_out,
    output logic                   rb_low,
    output logic      [7:0]        cmd_r,
    output logic      [39:0]       addr_r,
    output logic      [IO_W-1:0]   data_r,
    output int                     n_data,
    output int                     n_early
);
    int          acnt = 0;
    logic [11:0] col_r = '0;
    initial begin
        cmd_r = 8'h00;
        addr_r = '0;
        data_r = '0;
        n_data = 0;
        n_early = 0;
        rb_low = 1'b0;
        dev_out = '0;
    end
    // program and erase start only with write protect released
    always @(posedge ctl.we_n) begin
        if (!ctl.ce_n && ctl.cle) begin
            cmd_r = io[7:0];
            acnt = 0;
            if (io[7:0] == 8'h30 || ((io[7:0] == 8'h10 || io[7:0] == 8'hD0) && ctl.wp_n)) begin
                col_r = {addr_r[27:24], addr_r[39:32]};
                rb_low = 1'b1;
                fork
                    #BUSY_NS rb_low = 1'b0;
                join_none
            end
        end else if (!ctl.ce_n && ctl.ale) begin
            if (acnt < 5) addr_r = {addr_r[31:0], io[7:0]};
            acnt++;
        end else if (!ctl.ce_n) begin
            data_r = io;
            n_data++;
        end
    end
    always @(negedge ctl.re_n) begin
        if (!ctl.ce_n) begin
            if (rb_low) n_early++;
            dev_out = ~dev_out;
            #OUT_NS dev_out = IO_W'(col_r[7:0] ^ 8'hA5);
            col_r++;
        end
    end
    always @(posedge ctl.re_n or posedge ctl.ce_n)
        #10 dev_out = ~dev_out;
endmodule // nfc_flash_model

/* verification/test_nfc_host.sv */
// Purpose: self-checking bench for the flash bus host sequencer
// Assumes: byte bus, 20 MHz clk, device model on the pins
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module test_nfc_host;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              req_valid = 1'b0;
    logic              req_ready;
    nfc_pkg::nfc_req_s req = '0;
    logic              wr_valid = 1'b0;
    logic              wr_ready;
    logic [7:0]        wr_data = '0;
    logic              rd_valid;
    logic [7:0]        rd_data;
    logic              cmd_err;
    logic              write_protect = 1'b0;
    nfc_pkg::nfc_ctl_s ctl;
    logic [7:0]        io_out;
    logic              io_oe;
    logic [7:0]        dev_out;
    logic              rb_low;
    logic [7:0]        cmd_r;
    logic [39:0]       addr_r;
    logic [7:0]        data_r;
    logic [7:0]        rd_last = '0;
    int                n_data;
    int                n_early;
    int                n_err = 0;
    int                n_fail = 0;
    int                check_count = 0;
    int                cyc = 0;
    wire  [7:0]        io_in = io_oe ? io_out : dev_out;
    wire               ready_busy_n = rb_low ? 1'b0 : 1'b1;
    always #25 clk = ~clk;
    nfc_host #(.WIDE(1'b0)) u_nfc_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .cmd_err(cmd_err),
        .write_protect(write_protect), .ctl(ctl), .io_out(io_out), .io_oe(io_oe),
        .io_in(io_in), .ready_busy_n(ready_busy_n));
    nfc_flash_model u_nfc_flash_model (.ctl(ctl), .io(io_in), .dev_out(dev_out),
        .rb_low(rb_low), .cmd_r(cmd_r), .addr_r(addr_r), .data_r(data_r),
        .n_data(n_data), .n_early(n_early));
    always @(posedge clk) begin
        if (rd_valid === 1'b1) rd_last <= rd_data;
        if (cmd_err === 1'b1) n_err <= n_err + 1;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        check_count++;
        if (exp !== got) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // hold the request until taken, then wait for idle
    task automatic send(input nfc_pkg::nfc_op_e op, input logic [7:0] c,
                        input logic [11:0] col, input logic [17:0] row);
        logic ok;
        req = '{op: op, cmd: c, col: col, row: row};
        req_valid = 1'b1;
        do begin
            @(negedge clk);
            ok = req_ready;
            cycles(1);
        end while (!ok);
        req_valid = 1'b0;
        req.op = nfc_pkg::OP_CMD;
        do @(negedge clk); while (!req_ready);
        cycles(1);
    endtask
    task automatic t_cmd_addr();
        send(nfc_pkg::OP_CMD, 8'h00, '0, '0);
        chk("cmd", 40'h00, 40'(cmd_r));
        send(nfc_pkg::OP_ADDR, 8'h00, 12'h83F, 18'h2ABCD);
        chk("addr", 40'h3F08CDAB02, addr_r);
    endtask
    task automatic t_read();
        send(nfc_pkg::OP_CMD, 8'h30, '0, '0);
        chk("busy", 40'h0, 40'(ready_busy_n));
        send(nfc_pkg::OP_READ, 8'h00, '0, '0);
        chk("rd0", 40'h9A, 40'(rd_last));
        send(nfc_pkg::OP_READ, 8'h00, '0, '0);
        chk("rd1", 40'hE5, 40'(rd_last));
        chk("early", 40'h0, 40'(n_early));
    endtask
    task automatic t_err();
        send(nfc_pkg::OP_CMD, 8'h42, '0, '0);
        send(nfc_pkg::OP_ADDR, 8'h00, 12'd2112, '0);
        send(nfc_pkg::nfc_op_e'(3'h5), 8'h00, '0, '0);
        chk("errs", 40'h3, 40'(n_err));
        chk("cmd", 40'h30, 40'(cmd_r));
    endtask
    task automatic t_fifo();
        int i;
        int n0;
        n0 = n_data;
        wr_valid = 1'b1;
        for (i = 0; i < 12; i++) begin
            wr_data = 8'h10 + 8'(i);
            @(negedge clk);
            if (!wr_ready) break;
            cycles(1);
        end
        cycles(1);
        wr_valid = 1'b0;
        chk("fill", 40'd8, 40'(i));
        repeat (8) send(nfc_pkg::OP_WRITE, 8'h00, '0, '0);
        chk("words", 40'd8, 40'(n_data - n0));
        chk("last", 40'h17, 40'(data_r));
    endtask
    task automatic t_wp();
        write_protect = 1'b1;
        cycles(2);
        chk("wp_n", 40'h0, 40'(ctl.wp_n));
        send(nfc_pkg::OP_CMD, 8'h10, '0, '0);
        cycles(4);
        chk("prot", 40'h1, 40'(ready_busy_n));
        write_protect = 1'b0;
        cycles(2);
        send(nfc_pkg::OP_CMD, 8'h10, '0, '0);
        chk("prog", 40'h0, 40'(ready_busy_n));
        send(nfc_pkg::OP_WAIT, 8'h00, '0, '0);
        chk("ready", 40'h1, 40'(ready_busy_n));
        chk("ce_n", 40'h1, 40'(ctl.ce_n));
    endtask
    initial begin
        cycles(20);
        rst_n = 1'b1;
        cycles(2);
        t_cmd_addr();
        t_read();
        t_err();
        t_fifo();
        t_wp();
        give_verdict();
    end
endmodule // test_nfc_host
